// ===== mps_consts.svh
// timing constants for the modem power sequencer
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

// clock rate in kHz (20 MHz)
`define MPS_CLK_KHZ        20000

// times in their own units
`define MPS_PWR_ON_MS      25
`define MPS_RAIL_MS        25
`define MPS_BOOT_S         7
`define MPS_RESET_MS       20
`define MPS_READY_TMO_S    12
`define MPS_OFF_TMO_S      10

// least times round up, exact at this rate
`define MPS_PWR_ON_CYC     (`MPS_PWR_ON_MS * `MPS_CLK_KHZ)
`define MPS_RESET_CYC      (`MPS_RESET_MS * `MPS_CLK_KHZ)
// longest times round down, exact at this rate
`define MPS_RAIL_CYC       (`MPS_RAIL_MS * `MPS_CLK_KHZ)
`define MPS_BOOT_CYC       (`MPS_BOOT_S * 1000 * `MPS_CLK_KHZ)
`define MPS_READY_TMO_CYC  (`MPS_READY_TMO_S * 1000 * `MPS_CLK_KHZ)
`define MPS_OFF_TMO_CYC    (`MPS_OFF_TMO_S * 1000 * `MPS_CLK_KHZ)

`endif

// ===== mps_pkg.sv
// state types for the modem power sequencer
package mps_pkg;

    // modem end states
    typedef enum logic [1:0] {
        MPS_DS_OFF,
        MPS_DS_TRIG,
        MPS_DS_BOOT,
        MPS_DS_READY
    } mps_dev_state_t;

    // controller end states
    typedef enum logic [2:0] {
        MPS_HS_OFF,
        MPS_HS_IGNITE,
        MPS_HS_WAIT,
        MPS_HS_ON,
        MPS_HS_STOP,
        MPS_HS_KILL,
        MPS_HS_FAIL
    } mps_host_state_t;

endpackage : mps_pkg

// ===== mps_if.sv
// pad-level link between controller and modem
`timescale 1ns/1ns
interface mps_if;
    // power-on request pad, open drain with pull-up
    logic power_on_request_o;
    logic power_on_request_oe;
    logic power_on_request_n;
    // reset pad, open drain with pull-up
    logic reset_pad_o;
    logic reset_pad_oe;
    logic reset_pad_n;
    // modem indications
    logic io_rail_alive;
    logic serial_ready_flow;
    logic usb_enumerated;
    // command channel
    logic power_off_command;

    // pull-up wins unless driven
    assign power_on_request_n = power_on_request_oe ? power_on_request_o
                                                    : 1'b1;
    assign reset_pad_n        = reset_pad_oe ? reset_pad_o : 1'b1;

    modport host (
        output power_on_request_o,
        output power_on_request_oe,
        input  power_on_request_n,
        output reset_pad_o,
        output reset_pad_oe,
        input  reset_pad_n,
        input  io_rail_alive,
        input  serial_ready_flow,
        input  usb_enumerated,
        output power_off_command
    );

    modport device (
        input  power_on_request_n,
        input  reset_pad_n,
        output io_rail_alive,
        output serial_ready_flow,
        output usb_enumerated,
        input  power_off_command
    );
endinterface : mps_if

// ===== mps_device.sv
// modem end: power-up, switch-off and emergency reset behaviour
`timescale 1ns/1ns
`include "mps_consts.svh"
module mps_device import mps_pkg::*; #(
    parameter int unsigned TRIG_CYC  = `MPS_PWR_ON_CYC,
    parameter int unsigned RAIL_CYC  = `MPS_RAIL_CYC,
    parameter int unsigned BOOT_CYC  = `MPS_BOOT_CYC,
    parameter int unsigned RESET_CYC = `MPS_RESET_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // pad side
    mps_if.device     link,
    // user side
    input  wire logic usb_host_ready_i,
    output logic      cmd_ready_o,
    output logic      state_wiped_o
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (TRIG_CYC < 1 || RAIL_CYC < 1 || RESET_CYC < 1 ||
        BOOT_CYC <= TRIG_CYC || RAIL_CYC >= BOOT_CYC) begin : g_bad
        $error("mps_device: bad timing parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    mps_dev_state_t state_r, state_nxt;
    logic [31:0]    cnt_r, cnt_nxt;
    logic [31:0]    rst_cnt_r;
    logic [31:0]    rst_cnt_nxt;
    logic           rail_r, rail_nxt;
    logic           cts_r, cts_nxt;
    logic           usb_r, usb_nxt;
    logic           wiped_r;

    // pad decode
    wire pwr_low  = ~link.power_on_request_n;
    wire rst_low  = ~link.reset_pad_n;
    wire rst_hit  = rst_low && (rst_cnt_r == RESET_CYC - 1);
    wire trig_ok  = pwr_low && (cnt_r == TRIG_CYC - 1);
    wire boot_end = cnt_r == BOOT_CYC - 1;

    // reset pad low-time counter, saturating
    assign rst_cnt_nxt = !rst_low ? 32'h0 :
                         (rst_cnt_r == RESET_CYC) ? rst_cnt_r :
                         rst_cnt_r + 32'h1;

    // sequence decode
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 32'h1;
        if (rst_hit) begin
            // request low: boot again without a new trigger, else shut down
            state_nxt = pwr_low ? MPS_DS_BOOT : MPS_DS_OFF;
            cnt_nxt   = 32'h1;
        end else begin
            unique case (state_r)
                MPS_DS_OFF: begin
                    cnt_nxt = 32'h1;
                    if (pwr_low) begin
                        state_nxt = MPS_DS_TRIG;
                    end
                end
                MPS_DS_TRIG: begin
                    if (!pwr_low) begin
                        state_nxt = MPS_DS_OFF;   // too short a trigger
                    end else if (trig_ok) begin
                        state_nxt = MPS_DS_BOOT;
                    end
                end
                MPS_DS_BOOT: begin
                    if (boot_end) begin
                        state_nxt = MPS_DS_READY;
                    end
                end
                MPS_DS_READY: begin
                    cnt_nxt = cnt_r;
                    if (link.power_off_command) begin
                        state_nxt = MPS_DS_OFF;
                    end
                end
            endcase
        end
    end

    // indications from next state
    always_comb begin
        // a restart drops the rail until the count reaches it again
        rail_nxt = (state_nxt == MPS_DS_READY) ||
                   ((state_nxt == MPS_DS_TRIG || state_nxt == MPS_DS_BOOT) &&
                    cnt_nxt >= RAIL_CYC);
        cts_nxt  = state_nxt != MPS_DS_READY;
        usb_nxt  = (state_nxt == MPS_DS_READY) && usb_host_ready_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r   <= MPS_DS_OFF;
            cnt_r     <= 32'h0;
            rst_cnt_r <= 32'h0;
            rail_r    <= 1'b0;
            cts_r     <= 1'b1;
            usb_r     <= 1'b0;
            wiped_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            rail_r    <= rail_nxt;
            cts_r     <= cts_nxt;
            usb_r     <= usb_nxt;
            wiped_r   <= rst_hit;
        end
    end

    // outputs
    assign link.io_rail_alive     = rail_r;
    assign link.serial_ready_flow = cts_r;
    assign link.usb_enumerated    = usb_r;
    assign cmd_ready_o            = ~cts_r;
    assign state_wiped_o          = wiped_r;

endmodule : mps_device

// ===== mps_host.sv
// controller end: drives the modem power-on and reset pads
// Operation
// - hold power-on request low 25 ms
// - rail indicator rises within 25 ms
// - commands usable about seven seconds later
// - serial ready shown by falling flow line
// - usb ready after enumeration, host dependent
// - release request pad after valid trigger
// - request pad only pulled low, never high
// - orderly switch-off by power-off command
// - emergency: reset low 20 ms, request high
// - emergency pulse shuts down, clears state
// - emergency only when commands go unanswered; kill_i forces it from any active state except during a reset pulse here
// - rail indicator low off, high on
// - reset pulse with request low restarts
`timescale 1ns/1ns
`include "mps_consts.svh"
module mps_host import mps_pkg::*; #(
    parameter int unsigned PWR_ON_CYC    = `MPS_PWR_ON_CYC,
    parameter int unsigned RESET_CYC     = `MPS_RESET_CYC,
    parameter int unsigned READY_TMO_CYC = `MPS_READY_TMO_CYC,
    parameter int unsigned OFF_TMO_CYC   = `MPS_OFF_TMO_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // pad side
    mps_if.host       link,
    // user commands, one-cycle pulses
    input  wire logic start_i,
    input  wire logic stop_i,
    input  wire logic kill_i,
    input  wire logic restart_i,
    // user status
    output logic      on_o,
    output logic      busy_o,
    output logic      failed_o,
    output logic      done_o
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (PWR_ON_CYC < 1 || RESET_CYC < 1 || OFF_TMO_CYC < 1 ||
        READY_TMO_CYC <= PWR_ON_CYC) begin : g_bad
        $error("mps_host: bad timing parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    mps_host_state_t state_r, state_nxt;
    logic [31:0]     cnt_r, cnt_nxt;
    logic            pwr_oe_r, pwr_oe_nxt;
    logic            rst_oe_r, rst_oe_nxt;
    logic            cmd_r, cmd_nxt;
    logic            hold_r, hold_nxt;
    logic            cts_prev_r;
    logic            on_r, on_nxt;
    logic            busy_r, busy_nxt;
    logic            fail_r, fail_nxt;
    logic            done_r, done_nxt;

    ////////////////////////////////////////////////////////////////////////
    // decode
    // falling flow line marks serial readiness
    wire cts_fell  = cts_prev_r && !link.serial_ready_flow;
    wire ready_ev  = cts_fell || link.usb_enumerated;
    wire ign_end   = cnt_r == PWR_ON_CYC - 1;
    wire rdy_tmo   = cnt_r == READY_TMO_CYC - 1;
    wire off_tmo   = cnt_r == OFF_TMO_CYC - 1;
    wire kill_end  = cnt_r == RESET_CYC - 1;
    wire rail_dead = !link.io_rail_alive;

    ////////////////////////////////////////////////////////////////////////
    // sequence
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r + 32'h1;
        pwr_oe_nxt = 1'b0;
        rst_oe_nxt = 1'b0;
        cmd_nxt    = 1'b0;
        hold_nxt   = hold_r;
        done_nxt   = 1'b0;
        unique case (state_r)
            MPS_HS_OFF: begin
                cnt_nxt = 32'h0;
                if (start_i) begin
                    state_nxt  = MPS_HS_IGNITE;
                    pwr_oe_nxt = 1'b1;
                end
            end
            MPS_HS_IGNITE: begin
                pwr_oe_nxt = 1'b1;
                if (ign_end) begin
                    // trigger is valid, let the pad float
                    state_nxt  = MPS_HS_WAIT;
                    pwr_oe_nxt = 1'b0;
                end
            end
            MPS_HS_WAIT: begin
                if (ready_ev) begin
                    state_nxt = MPS_HS_ON;
                    done_nxt  = 1'b1;
                end else if (rdy_tmo) begin
                    state_nxt = MPS_HS_FAIL;
                    done_nxt  = 1'b1;
                end
            end
            MPS_HS_ON: begin
                cnt_nxt = 32'h0;
                if (rail_dead) begin
                    state_nxt = MPS_HS_OFF;
                    done_nxt  = 1'b1;
                end else if (stop_i) begin
                    // orderly switch-off over the command channel
                    state_nxt = MPS_HS_STOP;
                    cmd_nxt   = 1'b1;
                end else if (restart_i) begin
                    state_nxt  = MPS_HS_KILL;
                    hold_nxt   = 1'b1;
                    rst_oe_nxt = 1'b1;
                    pwr_oe_nxt = 1'b1;
                end
            end
            MPS_HS_STOP: begin
                if (rail_dead) begin
                    state_nxt = MPS_HS_OFF;
                    done_nxt  = 1'b1;
                end else if (off_tmo) begin
                    // modem did not answer, escalate
                    state_nxt  = MPS_HS_KILL;
                    cnt_nxt    = 32'h0;
                    hold_nxt   = 1'b0;
                    rst_oe_nxt = 1'b1;
                end
            end
            MPS_HS_KILL: begin
                rst_oe_nxt = 1'b1;
                pwr_oe_nxt = hold_r;
                if (kill_end) begin
                    rst_oe_nxt = 1'b0;
                    pwr_oe_nxt = 1'b0;
                    cnt_nxt    = 32'h0;
                    hold_nxt   = 1'b0;
                    if (hold_r) begin
                        state_nxt = MPS_HS_WAIT;
                    end else begin
                        state_nxt = MPS_HS_OFF;
                        done_nxt  = 1'b1;
                    end
                end
            end
            MPS_HS_FAIL: begin
                cnt_nxt = 32'h0;
                if (kill_i) begin
                    // frozen modem: emergency power off
                    state_nxt  = MPS_HS_KILL;
                    hold_nxt   = 1'b0;
                    rst_oe_nxt = 1'b1;
                end
            end
        endcase
        // kill from any active state except during a pulse
        if (kill_i && state_r != MPS_HS_OFF && state_r != MPS_HS_KILL &&
            state_r != MPS_HS_FAIL) begin
            state_nxt  = MPS_HS_KILL;
            cnt_nxt    = 32'h0;
            hold_nxt   = 1'b0;
            rst_oe_nxt = 1'b1;
            pwr_oe_nxt = 1'b0;
            cmd_nxt    = 1'b0;
            done_nxt   = 1'b0;
        end
    end

    // status from next state
    always_comb begin
        on_nxt   = state_nxt == MPS_HS_ON;
        fail_nxt = state_nxt == MPS_HS_FAIL;
        busy_nxt = (state_nxt != MPS_HS_OFF) && (state_nxt != MPS_HS_ON) &&
                   (state_nxt != MPS_HS_FAIL);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r    <= MPS_HS_OFF;
            cnt_r      <= 32'h0;
            pwr_oe_r   <= 1'b0;
            rst_oe_r   <= 1'b0;
            cmd_r      <= 1'b0;
            hold_r     <= 1'b0;
            cts_prev_r <= 1'b1;
            on_r       <= 1'b0;
            busy_r     <= 1'b0;
            fail_r     <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            pwr_oe_r   <= pwr_oe_nxt;
            rst_oe_r   <= rst_oe_nxt;
            cmd_r      <= cmd_nxt;
            hold_r     <= hold_nxt;
            cts_prev_r <= link.serial_ready_flow;
            on_r       <= on_nxt;
            busy_r     <= busy_nxt;
            fail_r     <= fail_nxt;
            done_r     <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // open-drain pads: data is always low, only the enable moves
    assign link.power_on_request_o  = 1'b0;
    assign link.power_on_request_oe = pwr_oe_r;
    assign link.reset_pad_o         = 1'b0;
    assign link.reset_pad_oe        = rst_oe_r;
    assign link.power_off_command   = cmd_r;
    assign on_o                     = on_r;
    assign busy_o                   = busy_r;
    assign failed_o                 = fail_r;
    assign done_o                   = done_r;

endmodule : mps_host

// ===== mps_chk.sv
// concurrent checks on the pad link between controller and modem
`timescale 1ns/1ns
module mps_chk #(
    parameter int PWR_ON_CYC = 10,
    parameter int RAIL_CYC   = 10,
    parameter int BOOT_CYC   = 50,
    parameter int RESET_CYC  = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pads and enables
    input wire logic power_on_request_o,
    input wire logic power_on_request_oe,
    input wire logic power_on_request_n,
    input wire logic reset_pad_o,
    input wire logic reset_pad_oe,
    input wire logic reset_pad_n,
    // modem indications and command
    input wire logic io_rail_alive,
    input wire logic serial_ready_flow,
    input wire logic usb_enumerated,
    input wire logic power_off_command
);
    localparam int BOOT_GAP = BOOT_CYC - RAIL_CYC - 1;
    logic [31:0] req_lo_r;
    logic [31:0] rst_lo_r;

    ////////////////////////////////////////////////////////////////////////
    // consecutive low cycles on each pad
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            req_lo_r <= 32'h0;
            rst_lo_r <= 32'h0;
        end else begin
            req_lo_r <= power_on_request_n ? 32'h0 : req_lo_r + 32'h1;
            rst_lo_r <= reset_pad_n ? 32'h0 : rst_lo_r + 32'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////
    // properties
    property p_req_od;
        power_on_request_oe |-> !power_on_request_o;
    endproperty
    property p_rst_od;
        reset_pad_oe |-> !reset_pad_o;
    endproperty
    property p_req_len;
        $rose(power_on_request_n) && $past(reset_pad_n)
            |-> req_lo_r == PWR_ON_CYC;
    endproperty
    property p_rst_len;
        $rose(reset_pad_n) |-> rst_lo_r == RESET_CYC;
    endproperty
    property p_rail_up;
        !power_on_request_n && req_lo_r == RAIL_CYC - 1 |=> io_rail_alive;
    endproperty
    property p_boot;
        $rose(io_rail_alive)
            |-> ##BOOT_GAP serial_ready_flow ##1 !serial_ready_flow;
    endproperty
    property p_flow_rail;
        $fell(serial_ready_flow) |-> io_rail_alive;
    endproperty
    property p_usb;
        usb_enumerated |-> !serial_ready_flow && io_rail_alive;
    endproperty
    property p_off_cmd;
        power_off_command && !serial_ready_flow
            |=> !io_rail_alive && serial_ready_flow;
    endproperty
    property p_emerg;
        !reset_pad_n && power_on_request_n && rst_lo_r == RESET_CYC - 1
            |=> !io_rail_alive;
    endproperty
    property p_off_lvl;
        !io_rail_alive |-> serial_ready_flow;
    endproperty

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_req_od: assert property (p_req_od)
        else $error("request pad driven high");
    a_rst_od: assert property (p_rst_od)
        else $error("reset pad driven high");
    a_req_len: assert property (p_req_len)
        else $error("power-on request pulse length wrong");
    a_rst_len: assert property (p_rst_len)
        else $error("reset pulse length wrong");
    a_rail_up: assert property (p_rail_up)
        else $error("rail indicator late");
    a_boot: assert property (p_boot)
        else $error("serial ready at wrong time");
    a_flow_rail: assert property (p_flow_rail)
        else $error("ready shown with rail off");
    a_usb: assert property (p_usb)
        else $error("enumeration before ready");
    a_off_cmd: assert property (p_off_cmd)
        else $error("power-off command ignored");
    a_emerg: assert property (p_emerg)
        else $error("emergency pulse did not shut down");
    a_off_lvl: assert property (p_off_lvl)
        else $error("ready while rail off");

    // main scenarios seen
    c_rail: cover property ($rose(io_rail_alive));
    c_ready: cover property ($fell(serial_ready_flow));
    c_pulse: cover property ($rose(reset_pad_n));
    c_off: cover property (power_off_command);
endmodule : mps_chk

// ===== tb_module_power_sequencer.sv
// self-checking bench: both ends joined through the pad link
`timescale 1ns/1ns
module tb_module_power_sequencer;
    localparam int PWR  = 10;
    localparam int RAIL = 10;
    localparam int BOOT = 50;
    localparam int RST  = 8;
    localparam int OTMO = 40;
    logic       clk_i;
    logic       rst_n_i;
    logic       usb_host_ready_i;
    logic [3:0] cmd;
    logic       cmd_ready_o;
    logic       state_wiped_o;
    logic       on_o;
    logic       busy_o;
    logic       failed_o;
    logic       done_o;
    int         n_errors;
    int         samples_checked;
    int         n_wiped;

    ////////////////////////////////////////////////////////////////////////
    // both ends and the checker
    mps_if link_if ();
    mps_host #(.PWR_ON_CYC(PWR), .RESET_CYC(RST), .READY_TMO_CYC(100),
        .OFF_TMO_CYC(OTMO)) mps_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link_if), .start_i(cmd[0]), .stop_i(cmd[1]),
        .kill_i(cmd[2]), .restart_i(cmd[3]), .on_o(on_o),
        .busy_o(busy_o), .failed_o(failed_o), .done_o(done_o));
    mps_device #(.TRIG_CYC(PWR), .RAIL_CYC(RAIL), .BOOT_CYC(BOOT),
        .RESET_CYC(RST)) mps_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link_if), .usb_host_ready_i(usb_host_ready_i),
        .cmd_ready_o(cmd_ready_o), .state_wiped_o(state_wiped_o));
    mps_chk #(.PWR_ON_CYC(PWR), .RAIL_CYC(RAIL), .BOOT_CYC(BOOT),
        .RESET_CYC(RST)) mps_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .power_on_request_o(link_if.power_on_request_o),
        .power_on_request_oe(link_if.power_on_request_oe),
        .power_on_request_n(link_if.power_on_request_n),
        .reset_pad_o(link_if.reset_pad_o),
        .reset_pad_oe(link_if.reset_pad_oe),
        .reset_pad_n(link_if.reset_pad_n),
        .io_rail_alive(link_if.io_rail_alive),
        .serial_ready_flow(link_if.serial_ready_flow),
        .usb_enumerated(link_if.usb_enumerated),
        .power_off_command(link_if.power_off_command));

    // clock and wipe pulse counter
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (state_wiped_o === 1'b1) n_wiped++;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic step(inout int n);
        @(posedge clk_i);
        #1;
        n++;
    endtask : step

    task automatic pulse(input int k);
        @(posedge clk_i);
        #5 cmd[k] = 1'b1;
        @(posedge clk_i);
        #5 cmd = 4'h0;
    endtask : pulse

    task automatic wait_done(output int n);
        n = 0;
        while (done_o !== 1'b1 && n < 400) step(n);
        chk(32'(done_o), 32'h1);
    endtask : wait_done

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_refuse();
        int n;
        pulse(1);
        repeat (5) step(n);
        chk(32'(busy_o), 32'h0);
        chk(32'(link_if.io_rail_alive), 32'h0);
    endtask : t_refuse

    task automatic t_start(input logic usb);
        int n;
        usb_host_ready_i = usb;
        pulse(0);
        chk(32'(link_if.power_on_request_n), 32'h0);
        chk(32'(busy_o), 32'h1);
        n = 0;
        while (link_if.io_rail_alive !== 1'b1 && n < 400) step(n);
        chk(n, RAIL);
        chk(32'(link_if.power_on_request_n), 32'h1);
        chk(32'(link_if.serial_ready_flow), 32'h1);
        while (link_if.serial_ready_flow !== 1'b0 && n < 400) step(n);
        chk(n, BOOT);
        wait_done(n);
        step(n);
        chk(32'(on_o), 32'h1);
        chk(32'(cmd_ready_o), 32'h1);
        chk(32'(link_if.usb_enumerated), 32'(usb));
    endtask : t_start

    task automatic t_stop();
        int n;
        int w0;
        w0 = n_wiped;
        pulse(1);
        chk(32'(link_if.power_off_command), 32'h1);
        wait_done(n);
        chk(32'(n < OTMO), 32'h1);
        chk(32'(link_if.io_rail_alive), 32'h0);
        chk(32'(cmd_ready_o), 32'h0);
        chk(n_wiped, w0);
    endtask : t_stop

    task automatic t_kill();
        int n;
        int w0;
        w0 = n_wiped;
        pulse(2);
        chk(32'(link_if.reset_pad_n), 32'h0);
        chk(32'(link_if.power_on_request_n), 32'h1);
        wait_done(n);
        repeat (3) step(n);
        chk(n_wiped, w0 + 1);
        chk(32'(link_if.io_rail_alive), 32'h0);
        chk(32'(on_o), 32'h0);
    endtask : t_kill

    task automatic t_restart();
        int n;
        int w0;
        w0 = n_wiped;
        pulse(3);
        chk(32'(link_if.reset_pad_n), 32'h0);
        chk(32'(link_if.power_on_request_n), 32'h0);
        repeat (RST + 3) step(n);
        chk(n_wiped, w0 + 1);
        chk(32'(link_if.io_rail_alive), 32'h0);
        wait_done(n);
        step(n);
        chk(32'(on_o), 32'h1);
        chk(32'(link_if.io_rail_alive), 32'h1);
        t_kill();
    endtask : t_restart

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        rst_n_i = 1'b0;
        cmd = 4'h0;
        usb_host_ready_i = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        n_wiped = 0;
        repeat (4) @(posedge clk_i);
        #5 rst_n_i = 1'b1;
        t_refuse();
        t_start(1'b0);
        t_stop();
        t_start(1'b1);
        t_kill();
        t_start(1'b0);
        t_restart();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
endmodule : tb_module_power_sequencer
